//--- hw/rcsl_defines.svh
`ifndef RCSL_DEFINES_SVH
`define RCSL_DEFINES_SVH

// Register indices on the plain register port
`define RCSL_ADDR_RCS 2'h0
`define RCSL_ADDR_STK 2'h1
`define RCSL_ADDR_CFG_LO 2'h2
`define RCSL_ADDR_CFG_HI 2'h3

// Reset control/status bit positions
`define RCSL_RCS_PRIO_EN 7
`define RCSL_RCS_SW_BO_EN 6
`define RCSL_RCS_INSTR 4
`define RCSL_RCS_WD_TIMEOUT 3
`define RCSL_RCS_POWER_DOWN 2
`define RCSL_RCS_POR 1
`define RCSL_RCS_BROWNOUT 0

// Return stack pointer bit positions
`define RCSL_STK_FULL 7
`define RCSL_STK_UNF 6

// Configuration field values
`define RCSL_BROWNOUT_MODE_SW 2'h1

// Vectors
`define RCSL_RESET_VECTOR 21'h000000
`define RCSL_HI_IRQ_VECTOR 21'h000008
`define RCSL_LO_IRQ_VECTOR 21'h000018
`define RCSL_PC_STEP 21'h000002

`endif

//--- hw/rcsl_pkg.sv
package rcsl_pkg;
    // Power-managed state of the core when an event arrives
    typedef enum logic [3:0] {
        RCSL_MODE_FULL = 4'h1,
        RCSL_MODE_RUN = 4'h2,
        RCSL_MODE_IDLE = 4'h4,
        RCSL_MODE_SLEEP = 4'h8
    } rcsl_mode_e;
endpackage

//--- hw/rcsl_reset_cause.sv
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "rcsl_defines.svh"
// Summary of operation
// - Reset-insensitive registers are undefined at power-on, kept through other resets.
// - Watchdog wake-up resumes execution, touching only status bits.
// - Power-on: vector 0; sets enable, instruction, timeout, power-down; clears power-on, brown-out, stack.
// - Reset instruction: vector 0, clears only the reset-instruction flag.
// - Brown-out: vector 0, sets instruction, timeout, power-down flags, clears brown-out flag.
// - Pin reset in run mode sets TO; in idle or sleep also clears PD.
// - Pin reset at full power: vector 0, all flags unchanged.
// - Watchdog timeout while running: vector 0, clears TO flag only.
// - Stack full reset when enabled: vector 0, sets stack-full flag.
// - Stack underflow reset when enabled: vector 0, sets underflow flag.
// - Underflow without reset enable: program counter to 0, underflow flag set, no reset.
// - Watchdog timeout in idle or sleep wakes, resumes two bytes on, clears both flags.
// - Interrupt wake-up clears power-down and resumes two bytes past the sleep.
// - Interrupt wake-up with a global interrupt enable set jumps to vector 08h or 18h.
// - Brown-out mode 01: enable resets to 1 at power-on, holds otherwise; else 0.
// - Control/status: priority enable b7, sw enable b6, b5 unused, flags b4..b0.
// - Unimplemented bits read as zero.
// - Config bytes carry brown-out level, mode, delay, postscaler, watchdog mode, enables.
// - Every reset directs execution to address 0000h.
// - Stack flags clear only by software write or power-on.
// - Software brown-out enable acts and reads only in mode 01.
module rcsl_reset_cause
    import rcsl_pkg::*;
#(
    parameter int PC_W = 21
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Reset and wake events, one-cycle pulses
    input wire logic por_evt_i,
    input wire logic brownout_evt_i,
    input wire logic external_reset_pin_evt_i,
    input wire logic reset_instr_evt_i,
    input wire logic watchdog_timer_evt_i,
    input wire logic stack_full_evt_i,
    input wire logic stack_underflow_evt_i,
    input wire logic irq_wake_evt_i,
    input wire logic [3:0] mode_i,
    input wire logic high_irq_global_enable_i,
    input wire logic low_irq_global_enable_i,
    input wire logic irq_high_pending_i,
    input wire logic [PC_W-1:0] program_counter_i,
    input wire logic [4:0] stack_ptr_i,
    // Configuration bytes, static
    input wire logic [1:0] brownout_level_cfg_i,
    input wire logic [1:0] brownout_mode_cfg_i,
    input wire logic powerup_delay_disable_cfg_i,
    input wire logic [3:0] watchdog_postscale_cfg_i,
    input wire logic [1:0] watchdog_mode_cfg_i,
    input wire logic external_reset_pin_enable_i,
    input wire logic stack_fault_reset_enable_i,
    // Register port
    input wire logic [1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    // Core control
    output logic core_reset_o,
    output logic pc_load_o,
    output logic [PC_W-1:0] pc_load_value_o,
    output logic sw_brownout_enable_o,
    output logic irq_priority_enable_o
);

    // Refuse widths the vector logic cannot serve; the low vector needs five bits
    if (PC_W < 8 || PC_W > 21) begin : g_pc_w_check
        $error("rcsl_reset_cause: PC_W must be 8..21");
    end

    // ************************************************************
    // Integration notes
    // ************************************************************
    // The block only records causes and picks a vector; the timers that
    // stretch a reset and the comparators that detect a brown-out live
    // elsewhere and hand over one-cycle event pulses.
    // rst_i is the power-on reset itself. It must be held across at least
    // one clock edge, and the first event may arrive at the first edge
    // after its release.
    // All event pulses are sampled on the same edge. When several come
    // together, power-on wins, then brown-out, then the rest combine.
    // A control/status write that meets any reset or wake event is dropped, so software
    // never overwrites a cause that hardware is just recording.
    // core_reset_o and pc_load_o are registered one-cycle pulses, late by
    // one clock; the core must not act on the event pulses directly.
    // An underflow with the reset enable clear loads address zero but
    // leaves core_reset_o low, so control registers keep their contents.
    // Stack-full sets its flag even without the reset enable, as the
    // stack logic still reports a full stack.
    // The configuration inputs are expected static; a change is seen by
    // the next read and the next event without any resynchronisation.

    // ************************************************************
    // Event decode
    // ************************************************************
    // Mode flags; mode_i is one-hot, so an illegal code matches no mode
    // and then behaves as run mode for pin events
    logic in_full;
    logic in_run;
    logic in_lowpwr;
    // Decoded event classes
    logic pin_rst;
    logic wd_rst;
    logic wd_wake;
    logic stk_rst;
    logic unf_rst;
    logic unf_err;
    logic any_rst;
    logic flag_evt;
    logic sw_mode;

    // Core power state at the event
    assign in_full = (mode_i == RCSL_MODE_FULL);
    assign in_run = (mode_i == RCSL_MODE_RUN);
    assign in_lowpwr = (mode_i == RCSL_MODE_IDLE) || (mode_i == RCSL_MODE_SLEEP);

    // Pin only counts when the pin is enabled as reset
    assign pin_rst = external_reset_pin_evt_i && external_reset_pin_enable_i;
    // Watchdog restarts a running core
    assign wd_rst = watchdog_timer_evt_i && !in_lowpwr;
    assign wd_wake = watchdog_timer_evt_i && in_lowpwr;

    // Stack faults restart the core only when the reset enable is set
    assign stk_rst = stack_full_evt_i && stack_fault_reset_enable_i;
    assign unf_rst = stack_underflow_evt_i && stack_fault_reset_enable_i;
    assign unf_err = stack_underflow_evt_i && !stack_fault_reset_enable_i;

    // Every source that restarts the core
    assign any_rst = por_evt_i || brownout_evt_i || pin_rst || reset_instr_evt_i
                     || wd_rst || stk_rst || unf_rst;
    // Events that rewrite control/status bits; a write in the same cycle loses
    assign flag_evt = any_rst || wd_wake || irq_wake_evt_i;

    // software enable only in mode 01
    assign sw_mode = (brownout_mode_cfg_i == `RCSL_BROWNOUT_MODE_SW);

    // ************************************************************
    // Control/status flags
    // ************************************************************
    // Cause flags, kept in flops so a software write lasts until the next event
    logic irq_priority_enable_q;
    logic sw_brownout_enable_q;
    logic reset_instr_flag_q;
    logic watchdog_timeout_flag_q;
    logic power_down_flag_q;
    logic por_flag_q;
    logic brownout_flag_q;
    logic wr_rcs;
    logic wr_stk;

    // Register write decode
    assign wr_rcs = reg_we_i && (reg_addr_i == `RCSL_ADDR_RCS);
    assign wr_stk = reg_we_i && (reg_addr_i == `RCSL_ADDR_STK);

    // power-on beats brown-out beats others; hardware beats software
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_priority_enable_q <= 1'b0;
            reset_instr_flag_q <= 1'b1;
            watchdog_timeout_flag_q <= 1'b1;
            power_down_flag_q <= 1'b1;
            por_flag_q <= 1'b0;
            brownout_flag_q <= 1'b0;
        end else if (por_evt_i) begin
            // power-on event repeats the image on the clocked path
            irq_priority_enable_q <= 1'b0;
            reset_instr_flag_q <= 1'b1;
            watchdog_timeout_flag_q <= 1'b1;
            power_down_flag_q <= 1'b1;
            por_flag_q <= 1'b0;
            brownout_flag_q <= 1'b0;
        end else if (brownout_evt_i) begin
            // brown-out flags; power-on flag and priority enable untouched
            reset_instr_flag_q <= 1'b1;
            watchdog_timeout_flag_q <= 1'b1;
            power_down_flag_q <= 1'b1;
            brownout_flag_q <= 1'b0;
        end else if (flag_evt) begin
            // instruction clears only its own flag
            if (reset_instr_evt_i) begin
                reset_instr_flag_q <= 1'b0;
            end
            // pin outside full power sets timeout; full power keeps all
            if (pin_rst && !in_full) begin
                watchdog_timeout_flag_q <= 1'b1;
            end
            // pin in idle or sleep also clears power-down
            if (pin_rst && in_lowpwr) begin
                power_down_flag_q <= 1'b0;
            end
            // watchdog reset clears timeout; wake clears both
            if (wd_rst || wd_wake) begin
                watchdog_timeout_flag_q <= 1'b0;
            end
            if (wd_wake || irq_wake_evt_i) begin
                power_down_flag_q <= 1'b0;
            end
        end else if (wr_rcs) begin
            irq_priority_enable_q <= reg_wdata_i[`RCSL_RCS_PRIO_EN];
            reset_instr_flag_q <= reg_wdata_i[`RCSL_RCS_INSTR];
            watchdog_timeout_flag_q <= reg_wdata_i[`RCSL_RCS_WD_TIMEOUT];
            power_down_flag_q <= reg_wdata_i[`RCSL_RCS_POWER_DOWN];
            por_flag_q <= reg_wdata_i[`RCSL_RCS_POR];
            brownout_flag_q <= reg_wdata_i[`RCSL_RCS_BROWNOUT];
        end
    end

    // power-on sets the software enable; it is forced low outside
    // mode 01, so the flop only matters while that mode is selected
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            // Power-on image; masked to zero outside mode 01
            sw_brownout_enable_q <= 1'b1;
        end else if (!sw_mode) begin
            sw_brownout_enable_q <= 1'b0;
        end else if (por_evt_i) begin
            sw_brownout_enable_q <= 1'b1;
        end else if (wr_rcs && !flag_evt) begin
            sw_brownout_enable_q <= reg_wdata_i[`RCSL_RCS_SW_BO_EN];
        end
    end

    // ************************************************************
    // Stack fault flags
    // ************************************************************
    // Sticky fault flags, cleared only by power-on or by software
    logic stack_full_flag_q;
    logic stack_underflow_flag_q;
    // cleared only by power-on or software; set wins over clear
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stack_full_flag_q <= 1'b0;
            stack_underflow_flag_q <= 1'b0;
        end else if (por_evt_i) begin
            stack_full_flag_q <= 1'b0;
            stack_underflow_flag_q <= 1'b0;
        end else begin
            // stack full sets flag; stack logic sets it even without reset
            if (stack_full_evt_i) begin
                stack_full_flag_q <= 1'b1;
            end else if (wr_stk && !reg_wdata_i[`RCSL_STK_FULL]) begin
                stack_full_flag_q <= 1'b0;
            end
            if (stack_underflow_evt_i) begin
                stack_underflow_flag_q <= 1'b1;
            end else if (wr_stk && !reg_wdata_i[`RCSL_STK_UNF]) begin
                stack_underflow_flag_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Restart and wake vectors
    // ************************************************************
    // Next restart or wake vector, worked out from this cycle's events
    logic [PC_W-1:0] vec_d;
    logic load_d;
    always_comb begin
        load_d = 1'b1;
        // any reset goes to the reset vector; so does underflow
        vec_d = PC_W'(`RCSL_RESET_VECTOR);
        if (any_rst || unf_err) begin
            vec_d = PC_W'(`RCSL_RESET_VECTOR);
        end else if (irq_wake_evt_i
                     && (high_irq_global_enable_i || low_irq_global_enable_i)) begin
            vec_d = irq_high_pending_i ? PC_W'(`RCSL_HI_IRQ_VECTOR)
                                       : PC_W'(`RCSL_LO_IRQ_VECTOR);
        end else if (wd_wake || irq_wake_evt_i) begin
            // resume after the sleep instruction; likewise
            vec_d = program_counter_i + PC_W'(`RCSL_PC_STEP);
        end else begin
            load_d = 1'b0;
        end
    end

    // Vector and reset strobe registered so outputs come from flops
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pc_load_o <= 1'b0;
            pc_load_value_o <= '0;
            core_reset_o <= 1'b1;
        end else begin
            pc_load_o <= load_d;
            pc_load_value_o <= vec_d;
            // underflow error does not reset the core
            core_reset_o <= any_rst;
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    // field placement; unused bits zero
    // Data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_re_i) begin
            case (reg_addr_i)
                `RCSL_ADDR_RCS: reg_rdata_o <= {irq_priority_enable_q,
                                                sw_brownout_enable_q & sw_mode,
                                                1'b0,
                                                reset_instr_flag_q,
                                                watchdog_timeout_flag_q,
                                                power_down_flag_q,
                                                por_flag_q,
                                                brownout_flag_q};
                `RCSL_ADDR_STK: reg_rdata_o <= {stack_full_flag_q, stack_underflow_flag_q,
                                                1'b0, stack_ptr_i};
                `RCSL_ADDR_CFG_LO: reg_rdata_o <= {3'h0, brownout_level_cfg_i,
                                                   brownout_mode_cfg_i,
                                                   powerup_delay_disable_cfg_i};
                `RCSL_ADDR_CFG_HI: reg_rdata_o <= {external_reset_pin_enable_i,
                                                   watchdog_postscale_cfg_i,
                                                   watchdog_mode_cfg_i,
                                                   stack_fault_reset_enable_i};
                default: reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // nothing here is reset-insensitive; core keeps such registers
    // Level outputs straight from the flops, enable masked by the mode
    assign sw_brownout_enable_o = sw_brownout_enable_q & sw_mode;
    assign irq_priority_enable_o = irq_priority_enable_q;

endmodule
`default_nettype wire

//--- tb/rcsl_reset_cause_props.sv
`timescale 1ns/1ns
`default_nettype none
module rcsl_reset_cause_props #(
    parameter int PC_W = 21
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic por_evt_i,
    input wire logic brownout_evt_i,
    input wire logic external_reset_pin_evt_i,
    input wire logic reset_instr_evt_i,
    input wire logic watchdog_timer_evt_i,
    input wire logic stack_full_evt_i,
    input wire logic stack_underflow_evt_i,
    input wire logic irq_wake_evt_i,
    input wire logic [3:0] mode_i,
    input wire logic high_irq_global_enable_i,
    input wire logic low_irq_global_enable_i,
    input wire logic irq_high_pending_i,
    input wire logic [PC_W-1:0] program_counter_i,
    input wire logic [1:0] brownout_mode_cfg_i,
    input wire logic external_reset_pin_enable_i,
    input wire logic stack_fault_reset_enable_i,
    input wire logic [1:0] reg_addr_i,
    input wire logic reg_re_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic core_reset_o,
    input wire logic pc_load_o,
    input wire logic [PC_W-1:0] pc_load_value_o,
    input wire logic sw_brownout_enable_o
);
    // ************
    // Event checks
    // ************
    // Only a lone event has one fixed outcome, so mixed cycles are left alone
    logic [7:0] evts;
    logic dozing;
    assign evts = {por_evt_i, brownout_evt_i, external_reset_pin_evt_i, reset_instr_evt_i,
        watchdog_timer_evt_i, stack_full_evt_i, stack_underflow_evt_i, irq_wake_evt_i};
    assign dozing = mode_i[2] | mode_i[3];
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    property p_bit5_zero;
        $past(reg_re_i) && !$past(reg_addr_i[1]) |-> !reg_rdata_o[5];
    endproperty
    a_bit5_zero: assert property (p_bit5_zero) else $error("unused bit 5 read as one");
    property p_instr_vector;
        evts == 8'h10 |=> core_reset_o && pc_load_o && pc_load_value_o == '0;
    endproperty
    a_instr_vector: assert property (p_instr_vector) else $error("reset instr no vector");
    property p_wd_wake;
        evts == 8'h08 && dozing |=> pc_load_o && !core_reset_o
            && pc_load_value_o == PC_W'($past(program_counter_i) + 2);
    endproperty
    a_wd_wake: assert property (p_wd_wake) else $error("watchdog wake bad resume");
    property p_wd_run;
        evts == 8'h08 && !dozing |=> core_reset_o && pc_load_value_o == '0;
    endproperty
    a_wd_run: assert property (p_wd_run) else $error("watchdog run no reset");
    property p_irq_vector;
        evts == 8'h01 && dozing && (high_irq_global_enable_i || low_irq_global_enable_i)
            |=> pc_load_o && pc_load_value_o == ($past(irq_high_pending_i) ? 'h8 : 'h18);
    endproperty
    a_irq_vector: assert property (p_irq_vector) else $error("wake vector wrong");
    property p_unf_error;
        evts == 8'h02 && !stack_fault_reset_enable_i |=> !core_reset_o && pc_load_o
            && pc_load_value_o == '0;
    endproperty
    a_unf_error: assert property (p_unf_error) else $error("underflow error wrong");
    property p_pin_reset;
        evts == 8'h20 && external_reset_pin_enable_i |=> core_reset_o && pc_load_value_o == '0;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset no vector");
    property p_sw_brownout_enable_gate;
        brownout_mode_cfg_i != 2'h1 && $past(brownout_mode_cfg_i) != 2'h1 |-> !sw_brownout_enable_o;
    endproperty
    a_sw_brownout_enable_gate: assert property (p_sw_brownout_enable_gate) else $error("sw enable outside mode");
    property p_quiet;
        evts == 8'h00 |=> !core_reset_o && !pc_load_o;
    endproperty
    a_quiet: assert property (p_quiet) else $error("restart without event");
    c_wd_wake: cover property (evts == 8'h08 && dozing);
    c_irq_wake: cover property (evts == 8'h01 && dozing && high_irq_global_enable_i);
    c_unf_error: cover property (evts == 8'h02 && !stack_fault_reset_enable_i);
endmodule
bind rcsl_reset_cause rcsl_reset_cause_props #(.PC_W(PC_W)) props_u (.*);
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import rcsl_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] ev = 8'h00;
    logic [3:0] mode = 4'h1;
    logic gh = 1'b0, gl = 1'b0, hp = 1'b0, we = 1'b0, re = 1'b0, pe = 1'b1, se = 1'b1;
    logic [20:0] pc = 21'h000000, pv;
    logic [4:0] sp = 5'h00;
    logic [1:0] bm = 2'h3, addr = 2'h0;
    logic [7:0] wd = 8'h00, rd;
    logic cr, pl, sbo, ipo;
    // Expected {instr, timeout, power-down, power-on, brown-out, full, underflow}
    logic [6:0] f = 7'h70;
    logic ip = 1'b0, sb = 1'b0;
    int err_count = 0, check_count = 0;
    rcsl_reset_cause dut_u (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .por_evt_i(ev[7]), .brownout_evt_i(ev[6]),
        .external_reset_pin_evt_i(ev[5]), .reset_instr_evt_i(ev[4]),
        .watchdog_timer_evt_i(ev[3]), .stack_full_evt_i(ev[2]),
        .stack_underflow_evt_i(ev[1]), .irq_wake_evt_i(ev[0]), .mode_i(mode),
        .high_irq_global_enable_i(gh), .low_irq_global_enable_i(gl),
        .irq_high_pending_i(hp), .program_counter_i(pc), .stack_ptr_i(sp),
        .brownout_level_cfg_i(2'h2), .brownout_mode_cfg_i(bm),
        .powerup_delay_disable_cfg_i(1'b1), .watchdog_postscale_cfg_i(4'hA),
        .watchdog_mode_cfg_i(2'h1), .external_reset_pin_enable_i(pe),
        .stack_fault_reset_enable_i(se), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rd), .core_reset_o(cr), .pc_load_o(pl),
        .pc_load_value_o(pv), .sw_brownout_enable_o(sbo), .irq_priority_enable_o(ipo)
    );
    // ****************
    // Expectation math
    // ****************
    // Flags after lone event k; index 7 is power-on down to 0 for wake
    function automatic logic [6:0] nflags(int k, logic [3:0] m, logic [6:0] o);
        logic [6:0] n;
        n = o;
        case (k)
            7: n = 7'h70;
            6: n = {3'b111, o[3], 1'b0, o[1:0]};
            5: if (pe && !m[0]) n[5:4] = (m[2] | m[3]) ? 2'b10 : {1'b1, o[4]};
            4: n[6] = 1'b0;
            3: n[5:4] = (m[2] | m[3]) ? 2'b00 : {1'b0, o[4]};
            2: n[1] = 1'b1;
            1: n[0] = 1'b1;
            default: n[4] = 1'b0;
        endcase
        return n;
    endfunction
    // Returns {core reset, pc load, load value}
    function automatic logic [22:0] npc(int k, logic [3:0] m);
        case (k)
            5: return pe ? 23'h600000 : 23'h000000;
            3: return (m[2] | m[3]) ? {2'b01, pc + 21'h000002} : 23'h600000;
            1: return {se, 22'h200000};
            0: return {2'b01, (gh | gl) ? (hp ? 21'h000008 : 21'h000018) : pc + 21'h000002};
            default: return 23'h600000;
        endcase
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        we <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge sys_clk_i);
        we <= 1'b0;
        if (a == 2'h0) begin
            ip = d[7];
            sb = d[6] & (bm == 2'h1);
            f[6:2] = d[4:0];
        end
        if (a == 2'h1) f[1:0] = f[1:0] & d[7:6];
    endtask
    task automatic rdc(input logic [1:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        re <= 1'b1;
        addr <= a;
        @(posedge sys_clk_i);
        re <= 1'b0;
        @(negedge sys_clk_i);
        chk("reg_rdata_o", e, rd);
    endtask
    task automatic regs;
        rdc(2'h0, {ip, sb, 1'b0, f[6:2]});
        rdc(2'h1, {f[1:0], 1'b0, sp});
        chk("sw_brownout_enable_o", sb, sbo);
        chk("irq_priority_enable_o", ip, ipo);
    endtask
    // One event cycle with fresh side inputs, then the restart outputs
    task automatic fire(input logic [7:0] e, input logic [3:0] m, input logic s);
        int k;
        logic [22:0] x;
        k = 7;
        while (!e[k]) k--;
        @(posedge sys_clk_i);
        ev <= e;
        mode <= m;
        se <= s;
        pe <= ($urandom_range(3, 0) != 0);
        pc <= 21'($urandom) & 21'h1FFFFE;
        sp <= 5'($urandom);
        gh <= 1'($urandom);
        gl <= 1'($urandom);
        hp <= 1'($urandom);
        @(posedge sys_clk_i);
        ev <= 8'h00;
        x = npc(k, mode);
        f = nflags(k, mode, f);
        if (k == 7) sb = (bm == 2'h1);
        if (k == 7) ip = 1'b0;
        @(negedge sys_clk_i);
        chk("core_reset_o", x[22], cr);
        chk("pc_load_o", x[21], pl);
        if (x[21]) chk("pc_load_value_o", x[20:0], pv);
    endtask
    task automatic finish_test;
        $display("Checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    // Main sequence: reset image, config, corners, then random traffic
    initial begin
        int k;
        logic [3:0] m;
        void'($urandom(77567));
        repeat (2) @(posedge sys_clk_i);
        chk("core_reset_o", 1'b1, cr);
        rst_i <= 1'b0;
        regs();
        wreg(2'h3, 8'h00);
        rdc(2'h2, {3'h0, 2'h2, bm, 1'b1});
        rdc(2'h3, {pe, 4'hA, 2'h1, se});
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk_i);
            bm <= 2'(i);
            fire(8'h80, 4'h1, 1'b1);
            regs();
            wreg(2'h0, 8'($urandom));
            regs();
        end
        fire(8'h04, 4'h1, 1'b1);
        fire(8'h02, 4'h8, 1'b0);
        fire(8'h40, 4'h2, 1'b1);
        regs();
        wreg(2'h1, 8'h40);
        wreg(2'h0, 8'h00);
        fire(8'hD0, 4'h1, 1'b1);
        regs();
        repeat (300) begin
            k = $urandom_range(7, 0);
            m = (k == 0) ? 4'h4 << $urandom_range(1, 0) : 4'h1 << $urandom_range(3, 0);
            if ($urandom_range(2, 0) == 0) wreg(2'($urandom_range(1, 0)), 8'($urandom));
            fire(8'h01 << k, m, (k == 2) | 1'($urandom));
            regs();
        end
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        err_count++;
        finish_test();
    end
endmodule
`default_nettype wire
